/* rtl/dts_pkg.sv */
// package of constants for the disk transfer sequencer
package dts_pkg;
  localparam int WORD_W = 12;
  localparam int HOLD_W = 4;
  localparam int TRACKA_PER_WORD = 13;
  localparam int SHIFTS_PER_ADDR = 11;
  localparam logic [3:0] BT_WDE_SET = 4'hC;
  localparam logic [3:0] BT_TRACK_END = 4'hD;
  localparam logic [3:0] BT_WORD_END = 4'hE;
  localparam int ACC_TRK_A = 11;
  localparam int ACC_TRK_B = 10;
  localparam int ACC_TRK_C = 9;
  localparam int MB_MAINT_BIT = 9;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SEARCH_DELAY_NS = 60;
  localparam int WEP_DELAY_NS = 50;
  // least delays round up
  localparam int SEARCH_DELAY_CYC =
    (SEARCH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WEP_DELAY_CYC =
    (WEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] HOLD_RESET = 4'h0;
endpackage

/* rtl/dts_sequencer.sv */
// disk transfer sequencer: timing, shift pulses, end of transfer
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
// ****************************************************************
// Overview of operation
// - read overflow pulse comes from host count overflow only in read.
// - direction set by write load, cleared by read load and clear.
// - setting of search flop delayed so first strobe gives no shift.
// - start-clear from reset, power clear or clear command resets logic.
// - data buffer shift pulse on each track-A strobe while connected.
// - track-A strobe is the main timing strobe, thirteen per word.
// - maintenance track generators toggle on generator pulse per acc bit.
// - address bit compared during search only, ignored once connected.
// - end-of-word strobe from track C at bit-time fourteen.
// - end-of-track pulse on track B one at bit-time thirteen in gate.
// - maintenance generator pulse from timing command with mb bit nine.
// - transfer-in-progress set on load; cleared by count end events.
// - done flag set when transfer over and data end pulse occurs.
// - count synchronizer cleared on load, set at zero, toggles in read.
// - write data enable set at bit-time twelve, cleared at fourteen.
// - delayed word end pulse follows word end pulse by two clocks, eighty ns.
// - host data loaded into hold register on write break at T1.
// - write lock error when selected head has its lock switch set.
// - write current only when connected and direction is write.
// - combined error true for late, parity, lock or missing disk.
// - address load from either load command copies accumulator.
// ****************************************************************
module dts_sequencer #(
  parameter int HEADS = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic power_clear_i,
  input wire logic clear_command_i,
  input wire logic load_address_read_cmd_i,
  input wire logic load_address_write_cmd_i,
  input wire logic maint_timing_cmd_i,
  input wire logic [dts_pkg::WORD_W-1:0] buffered_accumulator_i,
  input wire logic [dts_pkg::WORD_W-1:0] host_buffer_i,
  input wire logic host_count_overflow_pulse_i,
  input wire logic data_end_pulse_i,
  input wire logic break_cycle_i,
  input wire logic host_t1_i,
  input wire logic track_a_i,
  input wire logic track_b_i,
  input wire logic track_c_sense_i,
  input wire logic address_track_bit_i,
  input wire logic address_increment_level_i,
  input wire logic [$clog2(HEADS)-1:0] extended_address_i,
  input wire logic [HEADS-1:0] write_lock_switch_i,
  input wire logic data_late_error_i,
  input wire logic parity_error_i,
  input wire logic missing_disk_error_i,
  input wire logic data_transfer_connected_i,
  input wire logic disk_serial_bit_i,
  output logic [dts_pkg::WORD_W-1:0] disk_address_o,
  output logic [dts_pkg::WORD_W-1:0] disk_data_buffer_o,
  output logic [dts_pkg::WORD_W-1:0] buffer_hold_register_o,
  output logic direction_write_o,
  output logic address_search_ff_o,
  output logic address_shift_pulse_o,
  output logic data_buffer_shift_pulse_o,
  output logic word_end_pulse_o,
  output logic word_end_pulse_delayed_o,
  output logic word_end_strobe_c_o,
  output logic end_of_track_pulse_o,
  output logic write_data_enable_ff_o,
  output logic read_overflow_pulse_o,
  output logic transfer_in_progress_o,
  output logic count_synchronizer_o,
  output logic transfer_done_flag_o,
  output logic data_request_enable_o,
  output logic address_match_o,
  output logic maint_generator_pulse_o,
  output logic maint_track_a_gen_o,
  output logic maint_track_b_gen_o,
  output logic maint_track_c_gen_o,
  output logic write_lock_error_o,
  output logic write_current_enable_o,
  output logic error_o,
  output logic write_parity_o,
  output logic [3:0] bit_time_o
);
  import dts_pkg::*;

  initial begin
    if (HEADS < 2 || HEADS > 256) begin
      $error("HEADS out of range");
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] ta_s_r, tb_s_r, tc_s_r, tbh_s_r;
  logic ta_d_r, tc_d_r;
  logic ta_rise, tc_rise;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ta_s_r <= 2'h0;
      tb_s_r <= 2'h0;
      tc_s_r <= 2'h0;
      tbh_s_r <= 2'h0;
      ta_d_r <= 1'h0;
      tc_d_r <= 1'h0;
    end else begin
      ta_s_r <= {ta_s_r[0], track_a_i};
      tb_s_r <= {tb_s_r[0], track_b_i};
      tc_s_r <= {tc_s_r[0], track_c_sense_i};
      tbh_s_r <= {tbh_s_r[0], address_track_bit_i};
      ta_d_r <= ta_s_r[1];
      tc_d_r <= tc_s_r[1];
    end
  end

  assign ta_rise = ta_s_r[1] & ~ta_d_r;
  assign tc_rise = tc_s_r[1] & ~tc_d_r;

  // ****************************************************************
  // start clear and commands
  // ****************************************************************
  logic start_clear;
  logic address_load_pulse;
  assign start_clear = reset_i | power_clear_i | clear_command_i;
  assign address_load_pulse =
    load_address_read_cmd_i | load_address_write_cmd_i;

  // ****************************************************************
  // bit-time counter: track-A strobes, aligned by track C
  // ****************************************************************
  logic [3:0] bit_time_r;
  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      bit_time_r <= 4'h0;
    end else if (tc_rise) begin
      bit_time_r <= 4'h0;
    end else if (ta_rise && bit_time_r != BT_WORD_END) begin
      bit_time_r <= bit_time_r + 4'h1;
    end
  end
  assign bit_time_o = bit_time_r;

  // a strobe moving the count k to k+1 is bit-time k+1; track C is the next
  logic word_end;
  assign word_end = tc_rise && bit_time_r == BT_WORD_END - 4'h1;

  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      word_end_strobe_c_o <= 1'h0;
      word_end_pulse_o <= 1'h0;
      end_of_track_pulse_o <= 1'h0;
    end else begin
      word_end_strobe_c_o <= word_end;
      word_end_pulse_o <= word_end;
      end_of_track_pulse_o <= ta_rise &&
        bit_time_r == BT_TRACK_END - 4'h1 &&
        tb_s_r[1] && write_data_enable_ff_o;
    end
  end

  // delayed word end pulse
  logic [WEP_DELAY_CYC-1:0] wep_dly_r;
  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      wep_dly_r <= '0;
    end else begin
      wep_dly_r <= {wep_dly_r[WEP_DELAY_CYC-2:0],
                    word_end_pulse_o};
    end
  end
  assign word_end_pulse_delayed_o = wep_dly_r[WEP_DELAY_CYC-1];

  // ****************************************************************
  // write data enable and parity gating
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      write_data_enable_ff_o <= 1'h0;
    end else if (word_end_pulse_o) begin
      write_data_enable_ff_o <= 1'h0;
    end else if (ta_rise && bit_time_r == BT_WDE_SET - 4'h1) begin
      write_data_enable_ff_o <= 1'h1;
    end
  end
  assign write_parity_o = write_data_enable_ff_o & write_current_enable_o;

  // ****************************************************************
  // direction, address register, search
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      direction_write_o <= 1'h0;
    end else if (load_address_write_cmd_i) begin
      direction_write_o <= 1'h1;
    end else if (load_address_read_cmd_i) begin
      direction_write_o <= 1'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      disk_address_o <= '0;
    end else if (address_load_pulse) begin
      disk_address_o <= buffered_accumulator_i;
    end else if (address_shift_pulse_o) begin
      disk_address_o <= {disk_address_o[WORD_W-2:0],
                         address_increment_level_i};
    end
  end

  // first strobe sets a pending flag; search takes effect after delay
  logic [SEARCH_DELAY_CYC-1:0] sad_dly_r;
  logic first_strobe;
  assign first_strobe = ta_rise && bit_time_r == 4'h0;
  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      sad_dly_r <= '0;
    end else begin
      sad_dly_r <= {sad_dly_r[SEARCH_DELAY_CYC-2:0],
                    first_strobe && !address_search_ff_o &&
                    data_request_enable_o};
    end
  end

  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      address_search_ff_o <= 1'h0;
    end else if (write_data_enable_ff_o) begin
      address_search_ff_o <= 1'h0;
    end else if (sad_dly_r[SEARCH_DELAY_CYC-1]) begin
      address_search_ff_o <= 1'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      address_shift_pulse_o <= 1'h0;
      data_buffer_shift_pulse_o <= 1'h0;
    end else begin
      address_shift_pulse_o <= ta_rise & address_search_ff_o;
      data_buffer_shift_pulse_o <=
        ta_rise & data_transfer_connected_i;
    end
  end

  // address compare, gated off once connected
  always_ff @(posedge clk_i) begin
    if (start_clear || address_load_pulse) begin
      address_match_o <= 1'h1;
    end else if (address_shift_pulse_o && !data_transfer_connected_i &&
                 tbh_s_r[1] != address_increment_level_i) begin
      address_match_o <= 1'h0;
    end
  end

  // ****************************************************************
  // data buffer and hold register
  // ****************************************************************
  logic buffer_load_pulse;
  logic write_hold_load_pulse;
  assign buffer_load_pulse =
    word_end_pulse_o & data_transfer_connected_i & direction_write_o;
  assign write_hold_load_pulse =
    direction_write_o & break_cycle_i & host_t1_i;

  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      disk_data_buffer_o <= '0;
    end else if (buffer_load_pulse) begin
      disk_data_buffer_o <= buffer_hold_register_o;
    end else if (data_buffer_shift_pulse_o) begin
      disk_data_buffer_o <= {disk_data_buffer_o[WORD_W-2:0],
                             disk_serial_bit_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      buffer_hold_register_o <= '0;
    end else if (write_hold_load_pulse) begin
      buffer_hold_register_o <= host_buffer_i;
    end else if (!direction_write_o && word_end_pulse_o &&
                 data_transfer_connected_i) begin
      buffer_hold_register_o <= disk_data_buffer_o;
    end
  end

  // ****************************************************************
  // word count and end of transfer
  // ****************************************************************
  assign read_overflow_pulse_o =
    host_count_overflow_pulse_i & ~direction_write_o;

  always_ff @(posedge clk_i) begin
    if (start_clear || address_load_pulse) begin
      count_synchronizer_o <= 1'h0;
    end else if (read_overflow_pulse_o) begin
      count_synchronizer_o <= ~count_synchronizer_o;
    end else if (host_count_overflow_pulse_i) begin
      count_synchronizer_o <= 1'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      transfer_in_progress_o <= 1'h0;
    end else if (address_load_pulse) begin
      transfer_in_progress_o <= 1'h1;
    end else if (read_overflow_pulse_o) begin
      transfer_in_progress_o <= ~transfer_in_progress_o;
    end else if (buffer_load_pulse && count_synchronizer_o) begin
      transfer_in_progress_o <= 1'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (start_clear || address_load_pulse) begin
      transfer_done_flag_o <= 1'h0;
    end else if (!transfer_in_progress_o && data_end_pulse_i) begin
      transfer_done_flag_o <= 1'h1;
    end
  end

  // ****************************************************************
  // sixteen-word request holdoff
  // ****************************************************************
  logic request_synchronizer_r;
  logic [HOLD_W-1:0] holdoff_r;
  logic holdoff_count_bit3;
  assign holdoff_count_bit3 = holdoff_r[HOLD_W-1];

  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      holdoff_r <= HOLD_RESET;
    end else if (word_end_pulse_o && request_synchronizer_r) begin
      holdoff_r <= holdoff_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      request_synchronizer_r <= 1'h0;
      data_request_enable_o <= 1'h0;
    end else if (address_load_pulse) begin
      request_synchronizer_r <= 1'h1;
      data_request_enable_o <= 1'h0;
    end else if (word_end_pulse_o && request_synchronizer_r &&
                 holdoff_count_bit3 && holdoff_r[2:0] == 3'h7) begin
      request_synchronizer_r <= 1'h0;
      data_request_enable_o <= 1'h1;
    end
  end

  // ****************************************************************
  // maintenance track generators
  // ****************************************************************
  assign maint_generator_pulse_o =
    maint_timing_cmd_i & host_buffer_i[MB_MAINT_BIT];

  always_ff @(posedge clk_i) begin
    if (start_clear) begin
      maint_track_a_gen_o <= 1'h0;
      maint_track_b_gen_o <= 1'h0;
      maint_track_c_gen_o <= 1'h0;
    end else if (maint_generator_pulse_o) begin
      maint_track_a_gen_o <=
        maint_track_a_gen_o ^ buffered_accumulator_i[ACC_TRK_A];
      maint_track_b_gen_o <=
        maint_track_b_gen_o ^ buffered_accumulator_i[ACC_TRK_B];
      maint_track_c_gen_o <=
        maint_track_c_gen_o ^ buffered_accumulator_i[ACC_TRK_C];
    end
  end

  // ****************************************************************
  // write gating and errors
  // ****************************************************************
  assign write_lock_error_o =
    write_lock_switch_i[extended_address_i];
  assign write_current_enable_o =
    data_transfer_connected_i & direction_write_o;
  assign error_o = data_late_error_i | parity_error_i |
    write_lock_error_o | missing_disk_error_i;

  // ****************************************************************
  // assertions
  // ****************************************************************
  read_overflow_pulse_dir_a: assert property (@(posedge clk_i) disable iff (reset_i)
    read_overflow_pulse_o |-> !direction_write_o)
    else $error("read overflow during write");
  dir_load_a: assert property (@(posedge clk_i) disable iff (reset_i)
    load_address_write_cmd_i && !start_clear |=> direction_write_o)
    else $error("direction not set by write load");
  search_delay_a: assert property (@(posedge clk_i)
    disable iff (reset_i)
    first_strobe |=> !address_shift_pulse_o)
    else $error("shift on first strobe");
  shift_pulse_a: assert property (@(posedge clk_i)
    disable iff (reset_i)
    address_shift_pulse_o |=> !address_shift_pulse_o)
    else $error("shift pulse longer than one cycle");
  wep_delay_a: assert property (@(posedge clk_i)
    disable iff (start_clear)
    word_end_pulse_o |-> ##2 word_end_pulse_delayed_o)
    else $error("delayed word end missing");
  wde_clear_a: assert property (@(posedge clk_i)
    disable iff (start_clear)
    word_end_pulse_o |=> !write_data_enable_ff_o)
    else $error("write enable not cleared at word end");
  done_flag_a: assert property (@(posedge clk_i)
    disable iff (start_clear)
    !transfer_in_progress_o && data_end_pulse_i && !address_load_pulse
    |=> transfer_done_flag_o)
    else $error("done flag not set");
  wte_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
    write_current_enable_o |-> direction_write_o)
    else $error("write current in read");
  maint_clear_a: assert property (@(posedge clk_i)
    start_clear |=> !maint_track_a_gen_o && !maint_track_c_gen_o)
    else $error("maintenance generators not cleared");
endmodule

/* dv/dts_disk_model.sv */
// disk timing track model driving the sequencer pins
`timescale 1ns/10ps
module dts_disk_model (
  input wire logic run_i,
  input wire logic eot_i,
  output logic track_a_o,
  output logic track_b_o,
  output logic track_c_o
);
  // ****
  // timing tracks, still while not running
  // ****
  initial begin
    track_a_o = 1'b0;
    track_b_o = 1'b0;
    track_c_o = 1'b0;
    #7;
    forever begin
      if (!run_i) begin
        #40;
      end else begin
        // thirteen strobes per word
        for (int i = 0; i < 13; i++) begin
          track_a_o = 1'b1;
          track_b_o = (i == 12) & eot_i;
          #160;
          track_a_o = 1'b0;
          track_b_o = 1'b0;
          #160;
        end
        #320;
        track_c_o = 1'b1;
        #160;
        track_c_o = 1'b0;
        #480;
      end
    end
  end
endmodule

/* dv/disk_transfer_sequencer_tb.sv */
// self-checking bench for the disk transfer sequencer
`timescale 1ns/10ps
module disk_transfer_sequencer_tb;
  import dts_pkg::*;
  // ****
  // signals
  // ****
  logic clk_i, reset_i = 1'b1;
  logic pclr = 1'b0, clr = 1'b0, ldr = 1'b0, ldw = 1'b0, mcmd = 1'b0;
  logic hovf = 1'b0, dend = 1'b0, brk = 1'b0, t1 = 1'b0, atb = 1'b0;
  logic inc = 1'b0, conn = 1'b0, sbit = 1'b0, late = 1'b0, par = 1'b0;
  logic miss = 1'b0, run = 1'b0, eot = 1'b0, ta, tb, tc;
  logic [WORD_W-1:0] acc = '0, hbuf = '0, dadr, dbuf, hold;
  logic [3:0] ea = '0, bt;
  logic [15:0] lock = '0;
  logic dir, srch, ash, dbs, we, wed, wsc, eotp, wren, rof, tip, csy;
  logic done, rqe, amt, mgp, mga, mgb, mgc, wle, wcur, err, wpar;
  logic m_dir = 1'b0, we1 = 1'b0, we2 = 1'b0, ash1 = 1'b0;
  logic [2:0] m_mg = 3'h0;
  int n_fail = 0, n_tests = 0, n_words = 0, seed = 32'h663867C0;
  int n_ash = 0, n_dbs = 0, n_eot = 0, n_wr = 0, k_ash, k_dbs, k_eot, k_wr;

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  dts_disk_model dts_disk_model_inst (
    .run_i(run), .eot_i(eot), .track_a_o(ta), .track_b_o(tb),
    .track_c_o(tc)
  );

  dts_sequencer dts_sequencer_inst (
    .clk_i(clk_i), .reset_i(reset_i), .power_clear_i(pclr),
    .clear_command_i(clr), .load_address_read_cmd_i(ldr),
    .load_address_write_cmd_i(ldw), .maint_timing_cmd_i(mcmd),
    .buffered_accumulator_i(acc), .host_buffer_i(hbuf),
    .host_count_overflow_pulse_i(hovf), .data_end_pulse_i(dend),
    .break_cycle_i(brk), .host_t1_i(t1), .track_a_i(ta), .track_b_i(tb),
    .track_c_sense_i(tc), .address_track_bit_i(atb),
    .address_increment_level_i(inc), .extended_address_i(ea),
    .write_lock_switch_i(lock), .data_late_error_i(late),
    .parity_error_i(par), .missing_disk_error_i(miss),
    .data_transfer_connected_i(conn), .disk_serial_bit_i(sbit),
    .disk_address_o(dadr), .disk_data_buffer_o(dbuf),
    .buffer_hold_register_o(hold), .direction_write_o(dir),
    .address_search_ff_o(srch), .address_shift_pulse_o(ash),
    .data_buffer_shift_pulse_o(dbs), .word_end_pulse_o(we),
    .word_end_pulse_delayed_o(wed), .word_end_strobe_c_o(wsc),
    .end_of_track_pulse_o(eotp), .write_data_enable_ff_o(wren),
    .read_overflow_pulse_o(rof), .transfer_in_progress_o(tip),
    .count_synchronizer_o(csy), .transfer_done_flag_o(done),
    .data_request_enable_o(rqe), .address_match_o(amt),
    .maint_generator_pulse_o(mgp), .maint_track_a_gen_o(mga),
    .maint_track_b_gen_o(mgb), .maint_track_c_gen_o(mgc),
    .write_lock_error_o(wle), .write_current_enable_o(wcur),
    .error_o(err), .write_parity_o(wpar), .bit_time_o(bt)
  );

  // ****
  // reference model and tasks
  // ****
  task automatic check(string nm, logic [11:0] seen, logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one-cycle command: 0 pclr 1 clr 2 ldr 3 ldw 4 mcmd 5 hovf 6 dend
  task automatic cmd(int w);
    @(posedge clk_i);
    {dend, hovf, mcmd, ldw, ldr, clr, pclr} <= 7'(1 << w);
    @(posedge clk_i);
    {dend, hovf, mcmd, ldw, ldr, clr, pclr} <= 7'h0;
    @(negedge clk_i);
  endtask

  task automatic words(int n);
    int t;
    t = n_words + n;
    for (int i = 0; i < 200 * n && n_words < t; i++) @(negedge clk_i);
    check("word ends", 12'(n_words), 12'(t));
    repeat (4) @(negedge clk_i);
  endtask

  always @(posedge clk_i) begin
    we1 <= we;
    we2 <= we1;
    ash1 <= ash;
    if (reset_i | pclr | clr) begin
      m_dir <= 1'b0;
      m_mg <= 3'h0;
    end else begin
      if (ldw | ldr) m_dir <= ldw;
      if (mcmd & hbuf[MB_MAINT_BIT])
        m_mg <= m_mg ^ {acc[ACC_TRK_A], acc[ACC_TRK_B], acc[ACC_TRK_C]};
    end
    if (we === 1'b1) begin
      {k_ash, k_dbs, k_eot, k_wr} = {n_ash, n_dbs, n_eot, n_wr};
      {n_ash, n_dbs, n_eot, n_wr} = 128'h0;
      n_words++;
    end else begin
      n_ash += int'(ash === 1'b1);
      n_dbs += int'(dbs === 1'b1);
      n_eot += int'(eotp === 1'b1);
      n_wr += int'(wren === 1'b1);
    end
    if (run) {atb, inc, sbit} <= 3'($random(seed));
  end

  always @(negedge clk_i) begin
    if (reset_i === 1'b0) begin
      check("error", err, late | par | lock[ea] | miss);
      check("lock", wle, lock[ea]);
      check("current", wcur, conn & m_dir);
      check("overflow", rof, hovf & ~m_dir);
      check("maint pulse", mgp, mcmd & hbuf[MB_MAINT_BIT]);
      check("direction", dir, m_dir);
      check("maint gen", {mga, mgb, mgc}, m_mg);
      if (we2 === 1'b1 || wed !== 1'b0) check("end late", wed, we2);
      if (ash1 === 1'b1) check("shift width", ash, 1'b0);
      if (we1 === 1'b1) check("gate at end", wren, 1'b0);
    end
  end

  initial begin
    #1000000;
    n_fail++;
    print_verdict();
  end

  // ****
  // tests
  // ****
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    check("reset", {dir, tip, csy, done, rqe, mga, mgb, mgc}, 0);
    $display("test reset end");
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_i);
      ea <= 4'($random(seed));
      lock <= 16'($random(seed));
      acc <= 12'($random(seed));
      hbuf <= 12'($random(seed));
      {late, par, miss, conn, hovf, mcmd} <= 6'($random(seed));
      {ldw, ldr} <= (i % 8 == 0) ? 2'(1 + (i / 8) % 2) : 2'h0;
    end
    @(posedge clk_i);
    {late, par, miss, conn, hovf, mcmd, ldw, ldr} <= 8'h0;
    $display("test random levels end");
    for (int w = 0; w < 2; w++) begin
      @(posedge clk_i);
      acc <= 12'h5A3 ^ 12'(w);
      cmd(3);
      check("address", dadr, 12'h5A3 ^ 12'(w));
      check("loaded", {dir, tip, csy}, 3'b110);
      check("match", amt, 1'b1);
      cmd(w);
      check("cleared", {dir, tip, csy}, 3'h0);
    end
    for (int w = 0; w < 2; w++) begin
      cmd(3 - w);
      @(posedge clk_i);
      {brk, t1} <= 2'h3;
      hbuf <= w ? 12'hFFF : 12'h3C5;
      @(posedge clk_i);
      {brk, t1} <= 2'h0;
      @(negedge clk_i);
      check("hold", hold, 12'h3C5);
    end
    $display("test load and hold end");
    cmd(2);
    @(posedge clk_i);
    run <= 1'b1;
    words(15);
    check("request early", rqe, 1'b0);
    words(1);
    check("request", rqe, 1'b1);
    words(1);
    check("shifts", 12'(k_ash), 12'(SHIFTS_PER_ADDR));
    @(posedge clk_i);
    {conn, eot} <= 2'h3;
    words(1);
    check("data shifts", 12'(k_dbs), 12'(TRACKA_PER_WORD));
    check("track end", 12'(k_eot), 12'h001);
    check("gate seen", 12'(k_wr > 0), 12'h001);
    cmd(5);
    check("read end", {tip, csy}, 2'b01);
    cmd(6);
    repeat (3) @(negedge clk_i);
    check("done", done, 1'b1);
    @(posedge clk_i);
    {run, conn, eot} <= 3'h0;
    $display("test read transfer end");
    cmd(1);
    cmd(3);
    @(posedge clk_i);
    {run, conn} <= 2'h3;
    words(2);
    cmd(5);
    check("write count", {tip, csy}, 2'b11);
    words(1);
    check("write last", tip, 1'b0);
    cmd(6);
    repeat (3) @(negedge clk_i);
    check("write done", done, 1'b1);
    @(posedge clk_i);
    {run, conn} <= 2'h0;
    $display("test write transfer end");
    print_verdict();
  end
endmodule
